/* File: sim/lstg_panel_model.sv */
// display ram stand-in feeding rows back to the timing block
`include "lstg_map.svh"
module lstg_panel_model (
	input  wire logic                    i_clk,
	input  wire logic [`LSTG_LINE_W-1:0] i_line,
	input  wire logic [15:0]             i_key,
	output logic      [`LSTG_ROW_W-1:0]  o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// keyed by address so a wrong or stale row shows up, one cycle read latency
	always_ff @(posedge i_clk) begin
		o_data <= {8{i_key ^ {10'h000, i_line}}};
	end
endmodule // lstg_panel_model

/* File: sim/tb_lstg_timing.sv */
// self-checking bench of the scan timing generator
`include "lstg_map.svh"
module tb_lstg_timing;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk, rst_n, wr, rd, ext_ck, lp_in, flm_in, alt_in, ext_run, s;
	logic         lp, lp_oe, frame_start_marker, flm_oe, alt, alt_oe, exp_alt;
	logic [3:0]   addr;
	logic [7:0]   wdata, rdata, ctrl, ext_div;
	logic [5:0]   ram_line, exp_line;
	logic [127:0] ram_data, cols;
	logic [15:0]  key, rnd;
	logic [7:0]   exp_q[$];
	logic         rd_seen = 1'b0;
	int           bad_count, check_count, nl_n, nl_cnt;

	lstg_timing DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_EXTERNAL_SOURCE_CLOCK(ext_ck), .I_LINE_PULSE(lp_in),
		.O_LINE_PULSE(lp), .O_LINE_PULSE_OE(lp_oe), .I_FRAME_START_MARKER(flm_in),
		.O_FRAME_START_MARKER(frame_start_marker), .O_FRAME_START_MARKER_OE(flm_oe), .I_ALTERNATION(alt_in),
		.O_ALTERNATION(alt), .O_ALTERNATION_OE(alt_oe), .O_RAM_LINE(ram_line),
		.I_RAM_DATA(ram_data), .O_COLUMN_DRIVER_OUTPUTS(cols));
	lstg_panel_model ram (.i_clk(clk), .i_line(ram_line), .i_key(key), .o_data(ram_data));

	function automatic logic [15:0] lfsr(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [127:0] col_exp(logic [5:0] ln);
		logic [127:0] row;
		row = {8{key ^ {10'h000, ln}}};
		if (!ctrl[2]) return '0;
		if (ctrl[4]) return '1;
		return ctrl[3] ? ~row : row;
	endfunction
	task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(logic [3:0] a, logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(logic [3:0] a, logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(d);
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic set_ctrl(logic [7:0] d);
		ctrl = d;
		wr_reg(4'h0, d);
	endtask
	task automatic wait_lp(output logic seen);
		logic prev;
		seen = 1'b0;
		prev = lp;
		repeat (60) begin
			@(posedge clk);
			if (lp && !prev) begin
				seen = 1'b1;
				break;
			end
			prev = lp;
		end
	endtask
	task automatic run_lines(int k);
		logic e;
		repeat (k) begin
			wait_lp(e);
			check("line event", e, 1'b1);
			exp_line++;
			if (nl_n == 0) begin
				if (exp_line == 6'h00) exp_alt = ~exp_alt;
			end else if (++nl_cnt == nl_n) begin
				nl_cnt = 0;
				exp_alt = ~exp_alt;
			end
			check("ram line", ram_line, exp_line);
			check("frame marker", frame_start_marker, exp_line == 6'h00);
			check("alternation", alt, exp_alt);
			repeat (3) @(posedge clk);
			check("columns", cols, col_exp(exp_line));
		end
	endtask
	// secondary chip: timing arrives on the pins from a primary
	task automatic sec_pulse(logic f);
		flm_in <= f;
		alt_in <= ~f;
		repeat (3) @(posedge clk);
		lp_in <= 1'b1;
		repeat (8) @(posedge clk);
		lp_in <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) check("read data", rdata, exp_q.pop_front());
		rd_seen <= rd;
	end
	// external source clock, stops in its last level when ext_run drops
	always @(posedge clk) begin
		ext_div <= ext_div + 8'h01;
		if (ext_run && ext_div[1:0] == 2'b11) ext_ck <= ~ext_ck;
	end
	initial begin
		repeat (10000) @(posedge clk);
		bad_count++;
		wrap_up;
	end
	initial begin
		{rst_n, wr, rd, ext_ck, lp_in, flm_in, alt_in, ext_run, exp_alt} = '0;
		addr = 4'h0;
		wdata = 8'h00;
		ext_div = 8'h00;
		exp_line = 6'h00;
		ctrl = 8'h04;
		rnd = lfsr(16'h0323);
		key = rnd;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_reg(4'h0, 8'h04);
		rd_reg(4'h1, 8'h00);
		rd_reg(4'h2, 8'h0f);
		rd_reg(4'h3, 8'h80);
		check("oe secondary", {lp_oe, flm_oe, alt_oe}, 3'b000);
		wr_reg(4'h9, 8'hff);
		rd_reg(4'h9, 8'h00);
		wr_reg(4'h2, 8'h01);
		rd_reg(4'h2, 8'h01);
		sec_pulse(1'b0);
		sec_pulse(1'b0);
		check("secondary line", ram_line, 6'h02);
		sec_pulse(1'b1);
		check("secondary wrap", ram_line, 6'h00);
		// own alternation still counts the frame start taken as a secondary
		exp_alt = ~exp_alt;
		set_ctrl(8'h05);
		check("oe primary", {lp_oe, flm_oe, alt_oe}, 3'b111);
		run_lines(70);
		set_ctrl(8'h0d);
		run_lines(2);
		set_ctrl(8'h15);
		run_lines(2);
		set_ctrl(8'h01);
		run_lines(2);
		set_ctrl(8'h1d);
		run_lines(2);
		rnd = lfsr(rnd);
		nl_n = int'(rnd[1:0]) + 2;
		wr_reg(4'h1, 8'(nl_n - 1));
		nl_cnt = 0;
		set_ctrl(8'h25);
		run_lines(2 * nl_n + 1);
		nl_n = 0;
		set_ctrl(8'h05);
		ext_run <= 1'b1;
		set_ctrl(8'h07);
		run_lines(3);
		ext_run <= 1'b0;
		wait_lp(s);
		check("no ticks without source", s, 1'b0);
		wrap_up;
	end
endmodule // tb_lstg_timing

/* File: src/lstg_line_latch.sv */
// row latch with display on/off, inversion and all-on applied at its output
`include "lstg_map.svh"
module lstg_line_latch import lstg_pkg::*; (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_strobe,
	input  wire logic [`LSTG_ROW_W-1:0] i_data,
	input  wire lstg_ctrl_s             i_ctrl,
	output logic      [`LSTG_ROW_W-1:0] o_seg
);
	logic [`LSTG_ROW_W-1:0] row;
	wire  [`LSTG_ROW_W-1:0] shown;
	wire  [`LSTG_ROW_W-1:0] next_seg;

	// the raw row is kept apart so that mode changes never alter stored data
	assign shown    = i_ctrl.invert ? ~row : row;
	assign next_seg = !i_ctrl.disp_on ? '0 :
	                  i_ctrl.all_on   ? '1 : shown;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			row   <= '0;
			o_seg <= '0;
		end else begin
			if (i_strobe) begin
				row <= i_data;
			end
			o_seg <= next_seg;
		end
	end

	blank_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$past(!i_ctrl.disp_on) |-> o_seg == '0)
		else $error("columns not blank while display off");

	row_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_strobe |=> $stable(row))
		else $error("row latch changed without strobe");

	row_take_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_strobe |=> row == $past(i_data))
		else $error("row latch missed the line data");

endmodule // lstg_line_latch

/* File: src/lstg_map.svh */
// register map, widths, reset values and timing counts of the scan timing block
`ifndef LSTG_MAP_SVH
`define LSTG_MAP_SVH

`define LSTG_ADDR_CTRL     4'h0
`define LSTG_ADDR_NLINE    4'h1
`define LSTG_ADDR_LINEDIV  4'h2
`define LSTG_ADDR_STATUS   4'h3

`define LSTG_CTRL_RST      6'h04
`define LSTG_NLINE_RST     6'h00
`define LSTG_LINEDIV_RST   8'h0f

`define LSTG_LINE_W        6
`define LSTG_ROW_W         128
`define LSTG_LAST_LINE     6'h3f
`define LSTG_FIRST_LINE    6'h00

`define LSTG_CLK_PERIOD_NS 100
`define LSTG_OSC_PERIOD_NS 1000
`define LSTG_OSC_DIV       (`LSTG_OSC_PERIOD_NS / `LSTG_CLK_PERIOD_NS)
`define LSTG_OSC_LAST      8'((`LSTG_OSC_DIV) - 1)

`endif

/* File: src/lstg_pkg.sv */
// types shared by the scan timing block
package lstg_pkg;

	typedef struct packed {
		logic multi_line_invert_enable_en;
		logic all_on;
		logic invert;
		logic disp_on;
		logic ext_src;
		logic primary;
	} lstg_ctrl_s;

	typedef struct packed {
		logic alt;
		logic frame_start_marker;
		logic lp;
	} lstg_timing_s;

endpackage

/* File: src/lstg_timing.sv */
// scan timing generator: line pulse, frame marker, alternation and line addressing
//
// Strobed register access and the register addresses were decided locally.
`include "lstg_map.svh"
// Contract
// - timing derives from external source clock or internal oscillator divider
// - primary/secondary select changes generator behaviour and timing pin direction
// - line counter step and row latch strobe both come from the line pulse
// - each line pulse addresses next RAM line, then latches its 128 bits
// - alternation and frame marker are generated from the line pulse
// - by default alternation flips once per frame
// - with multi-line invert enabled alternation flips every n lines, register n-1
// - primary drives the three timing pins, secondary takes them as inputs
// - row latch holds one line for a whole common period
// - inversion, on/off and all-on act on latched data, never on RAM
module lstg_timing import lstg_pkg::*; (
	input  wire logic                   I_CLK,
	input  wire logic                   I_RST_N,
	input  wire logic [3:0]             I_ADDR,
	input  wire logic [7:0]             I_WDATA,
	input  wire logic                   I_WR,
	input  wire logic                   I_RD,
	output logic      [7:0]             O_RDATA,
	input  wire logic                   I_EXTERNAL_SOURCE_CLOCK,
	input  wire logic                   I_LINE_PULSE,
	output logic                        O_LINE_PULSE,
	output logic                        O_LINE_PULSE_OE,
	input  wire logic                   I_FRAME_START_MARKER,
	output logic                        O_FRAME_START_MARKER,
	output logic                        O_FRAME_START_MARKER_OE,
	input  wire logic                   I_ALTERNATION,
	output logic                        O_ALTERNATION,
	output logic                        O_ALTERNATION_OE,
	output logic      [`LSTG_LINE_W-1:0] O_RAM_LINE,
	input  wire logic [`LSTG_ROW_W-1:0] I_RAM_DATA,
	output logic      [`LSTG_ROW_W-1:0] O_COLUMN_DRIVER_OUTPUTS
);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	// control registers
	lstg_ctrl_s              ctrl;
	logic [`LSTG_LINE_W-1:0] nline;
	logic [7:0]              line_div;

	// pin synchronisers: stage a feeds stage b only
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] sync_c;
	wire  [3:0] pin_raw;

	// timing state
	logic [7:0]              osc_cnt;
	logic [7:0]              tick_cnt;
	logic [`LSTG_LINE_W-1:0] line;
	logic [`LSTG_LINE_W-1:0] n_cnt;
	lstg_timing_s            gen;
	logic                    evt_d1;
	logic                    evt_d2;
	logic [7:0]              rdata;

	wire                     int_tick;
	wire                     ext_tick;
	wire                     tick;
	wire                     div_end;
	wire                     gen_evt;
	wire                     sec_evt;
	wire                     lp_evt;
	wire                     frame_in;
	wire                     alt_now;
	wire                     frame_wrap;
	wire                     n_end;
	wire                     alt_flip;
	wire [`LSTG_LINE_W-1:0]  next_line;
	wire [7:0]               next_rdata;
	wire [7:0]               status;

	assign pin_raw = {I_ALTERNATION, I_FRAME_START_MARKER,
	                  I_LINE_PULSE, I_EXTERNAL_SOURCE_CLOCK};

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			sync_c <= 4'h0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// register writes
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ctrl     <= `LSTG_CTRL_RST;
			nline    <= `LSTG_NLINE_RST;
			line_div <= `LSTG_LINEDIV_RST;
		end else if (I_WR) begin
			if (hit(I_ADDR, `LSTG_ADDR_CTRL)) begin
				ctrl <= I_WDATA[5:0];
			end
			if (hit(I_ADDR, `LSTG_ADDR_NLINE)) begin
				nline <= I_WDATA[5:0];
			end
			if (hit(I_ADDR, `LSTG_ADDR_LINEDIV)) begin
				line_div <= I_WDATA;
			end
		end
	end

	// read path, data in the cycle after the strobe; unmapped reads give zero
	assign status = {gen.frame_start_marker, alt_now, line};
	assign next_rdata = !I_RD                               ? 8'h00 :
	                    hit(I_ADDR, `LSTG_ADDR_CTRL)    ? {2'b00, ctrl} :
	                    hit(I_ADDR, `LSTG_ADDR_NLINE)   ? {2'b00, nline} :
	                    hit(I_ADDR, `LSTG_ADDR_LINEDIV) ? line_div :
	                    hit(I_ADDR, `LSTG_ADDR_STATUS)  ? status : 8'h00;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end
	assign O_RDATA = rdata;

	// source clock: external pin rising edges or the on-chip oscillator divider
	assign int_tick = (osc_cnt == `LSTG_OSC_LAST);
	assign ext_tick = sync_b[0] & ~sync_c[0];
	assign tick     = ctrl.ext_src ? ext_tick : int_tick;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			osc_cnt <= 8'h00;
		end else begin
			osc_cnt <= int_tick ? 8'h00 : osc_cnt + 8'h01;
		end
	end

	// line pulse: one every line_div+1 source ticks
	assign div_end = (tick_cnt == line_div);
	assign gen_evt = tick & div_end & ctrl.primary;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tick_cnt <= 8'h00;
		end else if (tick) begin
			tick_cnt <= div_end ? 8'h00 : tick_cnt + 8'h01;
		end
	end

	// a secondary follows the primary's pins and ignores its own divider
	assign sec_evt  = sync_b[1] & ~sync_c[1];
	assign frame_in = sync_b[2];
	assign lp_evt   = ctrl.primary ? gen_evt : sec_evt;

	// line counter, stepped only by the line pulse
	assign frame_wrap = (line == `LSTG_LAST_LINE);
	assign next_line  = (!ctrl.primary && frame_in) ? `LSTG_FIRST_LINE :
	                    frame_wrap ? `LSTG_FIRST_LINE :
	                    line + 6'h01;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			line <= `LSTG_FIRST_LINE;
		end else if (lp_evt) begin
			line <= next_line;
		end
	end
	assign O_RAM_LINE = line;

	// RAM answers one cycle after the address moves, so the latch strobe trails by two
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			evt_d1 <= 1'b0;
			evt_d2 <= 1'b0;
		end else begin
			evt_d1 <= lp_evt;
			evt_d2 <= evt_d1;
		end
	end

	// alternation: per frame, or every nline+1 lines when enabled
	assign n_end    = (n_cnt == nline);
	assign alt_flip = ctrl.multi_line_invert_enable_en ? n_end : (next_line == `LSTG_FIRST_LINE);

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			n_cnt <= 6'h00;
		end else if (lp_evt) begin
			n_cnt <= (n_end || !ctrl.multi_line_invert_enable_en) ? 6'h00 : n_cnt + 6'h01;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			gen <= 3'b010;
		end else begin
			if (gen_evt) begin
				gen.lp <= 1'b1;
			end else if (tick) begin
				gen.lp <= 1'b0;
			end
			if (lp_evt) begin
				gen.frame_start_marker <= (next_line == `LSTG_FIRST_LINE);
				if (alt_flip) begin
					gen.alt <= ~gen.alt;
				end
			end
		end
	end

	// pins driven only by a primary; a secondary's alternation is the primary's
	assign alt_now                 = ctrl.primary ? gen.alt : sync_b[3];
	assign O_LINE_PULSE            = gen.lp;
	assign O_FRAME_START_MARKER    = gen.frame_start_marker;
	assign O_ALTERNATION           = gen.alt;
	assign O_LINE_PULSE_OE         = ctrl.primary;
	assign O_FRAME_START_MARKER_OE = ctrl.primary;
	assign O_ALTERNATION_OE        = ctrl.primary;

	lstg_line_latch u_latch (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_strobe(evt_d2),
		.i_data  (I_RAM_DATA),
		.i_ctrl  (ctrl),
		.o_seg   (O_COLUMN_DRIVER_OUTPUTS)
	);

	line_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && ctrl.primary && !frame_wrap |=> line == $past(line) + 6'h01)
		else $error("line counter did not advance on line pulse");

	line_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && frame_wrap |=> line == 6'h00)
		else $error("line counter did not wrap");

	line_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!lp_evt |=> $stable(line))
		else $error("line address moved without line pulse");

	latch_delay_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt |-> ##2 evt_d2)
		else $error("row latch strobe not two cycles after line pulse");

	frame_first_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt |=> gen.frame_start_marker == (line == 6'h00))
		else $error("frame marker not tied to first line");

	alt_frame_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && !ctrl.multi_line_invert_enable_en && frame_wrap |=> gen.alt != $past(gen.alt))
		else $error("alternation did not flip at frame end");

	alt_steady_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && !ctrl.multi_line_invert_enable_en && ctrl.primary && !frame_wrap |=> $stable(gen.alt))
		else $error("alternation flipped inside a frame");

	alt_nline_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && ctrl.multi_line_invert_enable_en && n_end |=> gen.alt != $past(gen.alt) && n_cnt == 6'h00)
		else $error("alternation missed n-line flip");

	sec_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!ctrl.primary |-> !gen_evt && !O_LINE_PULSE_OE && !O_ALTERNATION_OE)
		else $error("secondary generates or drives timing");

	src_ext_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		ctrl.ext_src && !ext_tick |=> $stable(tick_cnt))
		else $error("line divider ran without external clock edge");

	read_status_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_RD && I_ADDR == 4'h3 |=> O_RDATA[5:0] == $past(line))
		else $error("status read does not show line counter");

	rd_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not zero outside a read");

	read_ctrl_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_RD && I_ADDR == `LSTG_ADDR_CTRL |=> O_RDATA == {2'b00, $past(ctrl)})
		else $error("control read does not show control register");

	read_nline_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_RD && I_ADDR == `LSTG_ADDR_NLINE |=> O_RDATA == {2'b00, $past(nline)})
		else $error("n-line read does not show n-line register");

	read_div_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_RD && I_ADDR == `LSTG_ADDR_LINEDIV |=> O_RDATA == $past(line_div))
		else $error("divider read does not show divider register");

	write_ctrl_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_WR && I_ADDR == `LSTG_ADDR_CTRL |=> ctrl == $past(I_WDATA[5:0]))
		else $error("control write did not land");

	write_nline_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_WR && I_ADDR == `LSTG_ADDR_NLINE |=> nline == $past(I_WDATA[5:0]))
		else $error("n-line write did not land");

	write_div_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_WR && I_ADDR == `LSTG_ADDR_LINEDIV |=> line_div == $past(I_WDATA))
		else $error("divider write did not land");

	osc_wrap_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		int_tick |=> osc_cnt == 8'h00)
		else $error("oscillator divider did not wrap");

	osc_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!int_tick |=> osc_cnt == $past(osc_cnt) + 8'h01)
		else $error("oscillator divider did not count");

	div_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tick && !div_end |=> tick_cnt == $past(tick_cnt) + 8'h01)
		else $error("line divider did not count a tick");

	lp_rise_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		gen_evt |=> O_LINE_PULSE)
		else $error("line pulse not raised on line event");

	lp_fall_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		tick && !gen_evt |=> !O_LINE_PULSE)
		else $error("line pulse not dropped on next tick");

	sec_frame_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!ctrl.primary && lp_evt && frame_in |=> line == `LSTG_FIRST_LINE)
		else $error("secondary ignored frame marker pin");

	sec_step_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!ctrl.primary && lp_evt && !frame_in && !frame_wrap |=> line == $past(line) + 6'h01)
		else $error("secondary line did not follow line pulse pin");

	ncnt_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && !ctrl.multi_line_invert_enable_en |=> n_cnt == 6'h00)
		else $error("n-line counter not cleared while disabled");

	alt_ncount_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		lp_evt && ctrl.multi_line_invert_enable_en && !n_end |=> $stable(gen.alt))
		else $error("alternation flipped inside an n-line group");

	flm_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!lp_evt |=> $stable(gen.frame_start_marker))
		else $error("frame marker moved without line pulse");

endmodule // lstg_timing
